/* File: banked_data_memory_status.sv */
// banked data memory with status and bank select register
//
// Notes on behaviour
// - status bit 5 selects bank one
// - 128 byte banks, twelve special locations first
// - bank one general ram mirrors bank zero
// - direct or pointer access, pointer uses bank bit
// - 68 general bytes, eight bits each
// - only status, pointer and general ram take writes; other locations read 00h
// - status decoded at 03h and 83h
// - flag-updating writes keep result flags instead
// - expiry and powerdown flags ignore software writes
// - bit ops, swap, store leave flags alone
// - status bits 7:6 plain bits reset zero
// - subtraction flags are inverted borrows
// - power-on status is 0001 1000
`timescale 1ns/1ps
`include "dmem_regs.svh"
module banked_data_memory_status (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [6:0] addr,
  input  wire logic       rd,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  input  wire logic       flags_upd,
  input  wire logic       z_upd,
  input  wire logic       z_val,
  input  wire logic       dc_upd,
  input  wire logic       dc_val,
  input  wire logic       c_upd,
  input  wire logic       c_val,
  input  wire logic       watchdog_clear_op,
  input  wire logic       sleep_op,
  input  wire logic       wdt_timeout,
  output logic [7:0]      rdata,
  output logic [7:0]      status,
  output logic [7:0]      indirect_pointer,
  output logic [7:0]      eff_addr
);
  logic                  rst_s1_reg;
  logic                  rst_s2_reg;
  logic                  rst_n;
  logic [7:0]            status_reg;
  logic [7:0]            status_next;
  logic [7:0]            ptr_reg;
  logic [7:0]            ptr_next;
  logic [7:0]            rdata_reg;
  logic [7:0]            rdata_next;
  logic [7:0]            full_addr;
  dmem_pkg::region_t     region;
  mem_if                 ram_port ();

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  function automatic dmem_pkg::region_t decode(input logic [6:0] off);
    if (off == `STATUS_ADDR) begin
      decode = dmem_pkg::region_status;
    end else if (off == `PTR_ADDR) begin
      decode = dmem_pkg::region_ptr;
    end else if (off >= `SFR_COUNT && off <= `GPR_LAST) begin
      decode = dmem_pkg::region_gpr;
    end else begin
      decode = dmem_pkg::region_none;
    end
  endfunction

  always_comb begin
    if (addr == `IND_ADDR) begin
      full_addr = {status_reg[`ST_BANK], ptr_reg[6:0]};
    end else begin
      full_addr = {status_reg[`ST_BANK], addr};
    end
  end

  assign region            = decode(full_addr[6:0]);
  assign ram_port.idx      = full_addr[6:0] - `SFR_COUNT;
  assign ram_port.we       = wr && (region == dmem_pkg::region_gpr);
  assign ram_port.wdata    = wdata;

  gpr_array u_gpr (
    .mclk  (mclk),
    .rst_n (rst_n),
    .port  (ram_port.ram)
  );

  always_comb begin
    status_next = status_reg;
    ptr_next    = ptr_reg;
    rdata_next  = rdata_reg;
    if (wr) begin
      unique case (region)
        dmem_pkg::region_status: begin
          status_next[7:5] = wdata[7:5];
          if (!flags_upd) begin
            status_next[2:0] = wdata[2:0];
          end
        end
        dmem_pkg::region_ptr: begin
          ptr_next = wdata;
        end
        dmem_pkg::region_gpr: begin
          ptr_next = ptr_reg;
        end
        dmem_pkg::region_none: begin
          ptr_next = ptr_reg;
        end
      endcase
    end
    if (flags_upd) begin
      if (z_upd) begin
        status_next[`ST_Z] = z_val;
      end
      if (dc_upd) begin
        status_next[`ST_DC] = dc_val;
      end
      if (c_upd) begin
        status_next[`ST_C] = c_val;
      end
    end
    if (wdt_timeout) begin
      status_next[`ST_WDX] = 1'b0;
    end else if (watchdog_clear_op) begin
      status_next[`ST_WDX] = 1'b1;
      status_next[`ST_PD]  = 1'b1;
    end else if (sleep_op) begin
      status_next[`ST_WDX] = 1'b1;
      status_next[`ST_PD]  = 1'b0;
    end
    if (rd) begin
      unique case (region)
        dmem_pkg::region_status: rdata_next = status_reg;
        dmem_pkg::region_ptr:    rdata_next = ptr_reg;
        dmem_pkg::region_gpr:    rdata_next = ram_port.rdata;
        dmem_pkg::region_none:   rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= `STATUS_POR;
      ptr_reg    <= `PTR_POR;
      rdata_reg  <= 8'h00;
    end else begin
      status_reg <= status_next;
      ptr_reg    <= ptr_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign rdata            = rdata_reg;
  assign status           = status_reg;
  assign indirect_pointer = ptr_reg;
  assign eff_addr         = full_addr;
endmodule // banked_data_memory_status

/* File: banked_data_memory_status_tb.sv */
// testbench for the banked data memory
`timescale 1ns/1ps
module banked_data_memory_status_tb;
  logic mclk = 0, rst_b = 0, rd = 0, wr = 0;
  logic [6:0] addr = '0;
  logic [7:0] wdata = '0, rdata, status, indirect_pointer, eff_addr;
  logic flags_upd, z_upd, z_val, dc_upd, dc_val, c_upd, c_val;
  logic watchdog_clear_op, sleep_op, wdt_timeout;
  int n_errors = 0, n_checks = 0;
  banked_data_memory_status dut (.*);
  core_model m (.*);
  initial forever #25 mclk = ~mclk;
  task chk(input string s, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task wrt(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge mclk);
    wr <= 0;
  endtask
  task rdc(input logic [6:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1;
    @(posedge mclk);
    rd <= 0;
    #1 chk("rdata", e, rdata);
  endtask
  task report_and_stop;
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst_b <= 1;
    repeat (3) @(posedge mclk);
    chk("status", 8'h18, status);
    rdc(7'h03, 8'h18);
    wrt(7'h0C, 8'h55);
    wrt(7'h03, 8'h20);
    rdc(7'h0C, 8'h55);
    rdc(7'h03, 8'h38);
    wrt(7'h04, 8'h0C);
    #1 chk("pointer", 8'h0C, indirect_pointer);
    chk("eff_addr", 8'h84, eff_addr);
    rdc(7'h00, 8'h55);
    wrt(7'h4F, 8'hA5);
    rdc(7'h4F, 8'hA5);
    rdc(7'h50, 8'h00);
    m.pulse(10'h002);
    wrt(7'h03, 8'hE7);
    #1 chk("status", 8'hF7, status);
    fork
      wrt(7'h03, 8'h00);
      m.pulse(10'h3D0);
    join
    #1 chk("status", 8'h14, status);
    wrt(7'h03, 8'h01);
    #1 chk("status", 8'h11, status);
    m.pulse(10'h001);
    #1 chk("status", 8'h01, status);
    m.pulse(10'h004);
    #1 chk("status", 8'h19, status);
    m.pulse(10'h278);
    #1 chk("status", 8'h1B, status);
    report_and_stop;
  end
endmodule // banked_data_memory_status_tb

/* File: core_model.sv */
// processor core model driving flag updates and power events
`timescale 1ns/1ps
module core_model (
  input  wire logic mclk,
  output logic      flags_upd,
  output logic      z_upd,
  output logic      z_val,
  output logic      dc_upd,
  output logic      dc_val,
  output logic      c_upd,
  output logic      c_val,
  output logic      watchdog_clear_op,
  output logic      sleep_op,
  output logic      wdt_timeout
);
  logic [9:0] ev = '0;
  assign {flags_upd, z_upd, z_val, dc_upd, dc_val, c_upd, c_val,
          watchdog_clear_op, sleep_op, wdt_timeout} = ev;
  // one-cycle event vector; carry values already inverted borrows
  task pulse(input logic [9:0] v);
    @(posedge mclk);
    ev <= v;
    @(posedge mclk);
    ev <= '0;
  endtask
endmodule // core_model

/* File: dmem_chk.sv */
// assertion checker for the banked data memory
`timescale 1ns/1ps
module dmem_chk (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic [6:0] addr,
  input wire logic       wr,
  input wire logic [7:0] wdata,
  input wire logic       flags_upd,
  input wire logic       z_upd,
  input wire logic       z_val,
  input wire logic       watchdog_clear_op,
  input wire logic       sleep_op,
  input wire logic       wdt_timeout,
  input wire logic [7:0] status,
  input wire logic [7:0] indirect_pointer,
  input wire logic [7:0] eff_addr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  bank_sel_a: assert property (
    addr != 7'h00 |-> eff_addr == {status[5], addr}) else $error("bank bit wrong");
  flag_prot_a: assert property (
    wr && !watchdog_clear_op && !sleep_op && !wdt_timeout |=> $stable(status[4:3]))
    else $error("power flags written");
  sleep_flags_a: assert property (
    sleep_op && !watchdog_clear_op && !wdt_timeout |=> status[4:3] == 2'b10)
    else $error("sleep flags wrong");
  wdt_flag_a: assert property (
    wdt_timeout |=> !status[4]) else $error("expiry flag not cleared");
  wclr_flags_a: assert property (
    watchdog_clear_op && !wdt_timeout |=> status[4:3] == 2'b11) else $error("clear flags wrong");
  zero_flag_a: assert property (
    flags_upd && z_upd |=> status[2] == $past(z_val)) else $error("zero flag wrong");
  ptr_write_a: assert property (
    wr && addr == 7'h04 |=> indirect_pointer == $past(wdata)) else $error("pointer not written");
  upper_bits_a: assert property (
    wr && addr == 7'h03 && !flags_upd |=> status[7:5] == $past(wdata[7:5]))
    else $error("upper status bits wrong");
  cover property (wr && addr == 7'h04);
  cover property (wr && flags_upd);
  cover property (sleep_op);
endmodule // dmem_chk
bind banked_data_memory_status dmem_chk chk_i (.*);

/* File: dmem_pkg.sv */
// types shared by the banked data memory files
package dmem_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [3:0] {
    region_status = 4'b0001,
    region_ptr    = 4'b0010,
    region_gpr    = 4'b0100,
    region_none   = 4'b1000
  } region_t;
endpackage

/* File: dmem_regs.svh */
// address map, field positions, reset values and sizes of the banked data memory
`ifndef DMEM_REGS_SVH
`define DMEM_REGS_SVH
`define STATUS_ADDR        7'h03
`define PTR_ADDR           7'h04
`define IND_ADDR           7'h00
`define SFR_COUNT          7'h0C
`define GPR_LAST           7'h4F
`define GPR_DEPTH          68
`define ST_UPPER_HI        7
`define ST_UPPER_LO        6
`define ST_BANK            5
`define ST_WDX             4
`define ST_PD              3
`define ST_Z               2
`define ST_DC              1
`define ST_C               0
`define STATUS_POR         8'h18
`define PTR_POR            8'h00
`endif

/* File: gpr_array.sv */
// 68 byte general ram array held in flip-flops
`timescale 1ns/1ps
`include "dmem_regs.svh"
module gpr_array (
  input  wire logic mclk,
  input  wire logic rst_n,
  mem_if.ram        port
);
  logic [7:0] mem_reg [`GPR_DEPTH];

  always_ff @(posedge mclk) begin
    if (port.we && port.idx < 7'(`GPR_DEPTH)) begin
      mem_reg[port.idx] <= port.wdata;
    end
  end

  assign port.rdata = (port.idx < 7'(`GPR_DEPTH)) ? mem_reg[port.idx] : 8'h00;
endmodule // gpr_array

/* File: mem_if.sv */
// access port between the decoder and the general ram array
`timescale 1ns/1ps
interface mem_if;
  logic [6:0] idx;
  logic       we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctl (output idx, output we, output wdata, input rdata);
  modport ram (input idx, input we, input wdata, output rdata);
endinterface
